// ---- testbench/dmc_chk.sv ----
// Purpose: bus and register port checks for the dma engine
// Assumes: one clock, synchronous active-low reset
// Notes:   cpu turn is tracked in helper logic, granted after reset
`timescale 1ns/100ps
`default_nettype none
module dmc_chk (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  reg_re_i,
  input wire logic [dmc_pkg::DW-1:0] reg_rdata_o,
  input wire logic                  cpu_access_done_i,
  input wire dmc_pkg::dmc_mem_req_t mem_req_o,
  input wire logic                  bus_hold_o
);
  logic turn_q;
  logic turn_d;
  always_comb begin
    turn_d = turn_q;
    if (bus_hold_o) begin
      turn_d = 1'b0;
    end else if (cpu_access_done_i) begin
      turn_d = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      turn_q <= 1'b1;
    end else begin
      turn_q <= turn_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // longest unit: two beats of three cycles each way
  sequence s_xfer;
    bus_hold_o [*2] ##[1:11] !bus_hold_o;
  endsequence
  sequence s_sfr_beat;
    mem_req_o.rd && $stable(mem_req_o.addr);
  endsequence
  a_hold_window: assert property ($rose(bus_hold_o) |-> s_xfer)
    else $error("bus hold length out of range");
  a_read_first: assert property ($rose(bus_hold_o) |-> mem_req_o.rd && !mem_req_o.wr)
    else $error("transfer does not open with a read");
  a_write_after_read: assert property ($rose(mem_req_o.wr) |-> $past(mem_req_o.rd))
    else $error("write not preceded by read");
  a_ends_on_write: assert property ($fell(bus_hold_o) |-> $past(mem_req_o.wr))
    else $error("bus released without a write");
  a_strobe_exclusive: assert property (!(mem_req_o.rd && mem_req_o.wr))
    else $error("read and write strobes together");
  a_idle_no_strobe: assert property (!bus_hold_o |-> !mem_req_o.rd && !mem_req_o.wr)
    else $error("strobe without bus hold");
  a_cpu_turn: assert property ($rose(bus_hold_o) |-> turn_q)
    else $error("bus taken without a cpu access between");
  a_sfr_two_cycles: assert property ($rose(mem_req_o.rd) && mem_req_o.addr < dmc_pkg::SFR_TOP
    |=> s_sfr_beat)
    else $error("sfr read shorter than two cycles");
  a_rdata_one_cycle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside its cycle");
endmodule : dmc_chk
bind dmc_top dmc_chk dmc_chk_i (
  .clk_i            (clk_i),
  .rst_n_i          (rst_n_i),
  .reg_re_i         (reg_re_i),
  .reg_rdata_o      (reg_rdata_o),
  .cpu_access_done_i(cpu_access_done_i),
  .mem_req_o        (mem_req_o),
  .bus_hold_o       (bus_hold_o)
);
`default_nettype wire

// ---- testbench/dmc_cpu_model.sv ----
// Purpose: cpu side of the shared bus for the dma bench
// Assumes: one cpu access every 4 cycles, or 16 when slow
// Notes:   read data depend on address; released lines toggle
`timescale 1ns/100ps
`default_nettype none
module dmc_cpu_model (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  slow_i,
  input  wire dmc_pkg::dmc_mem_req_t mem_req_i,
  input  wire logic                  bus_hold_i,
  output logic      [15:0]           mem_rdata_o,
  output logic                       cpu_done_o
);
  logic [3:0]  tick_q;
  logic [15:0] noise_q;
  logic        hold_q;
  logic        wr_q;
  logic [7:0]  rd_cnt;
  logic [7:0]  wr_cnt;
  logic [7:0]  n_rd;
  logic [7:0]  n_wr;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic [15:0] log_a [4];
  int          ntr;
  // a stale word on an idle bus would hide a mistimed sample
  assign mem_rdata_o = mem_req_i.rd ? (mem_req_i.addr ^ 16'hA5C3) : noise_q;
  always_ff @(posedge clk_i) begin
    hold_q <= bus_hold_i;
    wr_q   <= mem_req_i.wr;
    if (!rst_n_i) begin
      noise_q    <= 16'h0000;
      tick_q     <= 4'h0;
      cpu_done_o <= 1'b0;
      ntr        <= 0;
      rd_cnt     <= 8'h00;
      wr_cnt     <= 8'h00;
    end else begin
      noise_q    <= {noise_q[14:0], ~noise_q[15]};
      tick_q     <= bus_hold_i ? 4'h0 : tick_q + 4'h1;
      cpu_done_o <= !bus_hold_i && (slow_i ? tick_q == 4'hF : tick_q[1:0] == 2'h3);
      if (hold_q && !bus_hold_i) begin
        ntr    <= ntr + 1;
        n_rd   <= rd_cnt;
        n_wr   <= wr_cnt;
        rd_cnt <= 8'h00;
        wr_cnt <= 8'h00;
      end else begin
        rd_cnt <= rd_cnt + {7'h00, mem_req_i.rd};
        wr_cnt <= wr_cnt + {7'h00, mem_req_i.wr};
      end
      if (mem_req_i.wr) begin
        wr_addr <= mem_req_i.addr;
        wr_data <= mem_req_i.wdata;
      end
      if (mem_req_i.wr && !wr_q) begin
        log_a[ntr[1:0]] <= mem_req_i.addr;
      end
    end
  end
endmodule : dmc_cpu_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the two-channel dma engine
// Assumes: cpu model on the bus, bench plays the peripherals
// Notes:   channels stop at count zero, so the cycle table and priority tests reload the count first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                  clk_i;
  logic                  rst_n_i;
  logic [4:0]            reg_addr_i;
  logic [15:0]           reg_wdata_i;
  logic                  reg_we_i;
  logic                  reg_re_i;
  logic [15:0]           reg_rdata_o;
  logic [31:0]           irq_flag_i;
  logic                  cpu_done;
  logic [15:0]           mem_rdata;
  dmc_pkg::dmc_mem_req_t mem_req;
  logic                  bus_hold;
  logic                  slow_q;
  int                    fail_count;
  int                    n_tests;
  int                    cyc;
  localparam logic [15:0] T_SRC [6] = '{16'h2000, 16'h2001, 16'h2000, 16'h2000, 16'h0100, 16'h0101};
  localparam logic [15:0] T_DST [6] = '{16'h3000, 16'h3000, 16'h3001, 16'h3000, 16'h3000, 16'h3000};
  localparam logic [15:0] T_CFG [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0001};
  localparam logic [7:0]  T_RD  [6] = '{8'h01, 8'h02, 8'h01, 8'h02, 8'h02, 8'h06};
  localparam logic [7:0]  T_WR  [6] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h01, 8'h01};
  dmc_top dmc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .irq_flag_i(irq_flag_i), .cpu_access_done_i(cpu_done),
    .mem_rdata_i(mem_rdata), .mem_req_o(mem_req), .bus_hold_o(bus_hold));
  dmc_cpu_model dmc_cpu_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow_q),
    .mem_req_i(mem_req), .bus_hold_i(bus_hold), .mem_rdata_o(mem_rdata), .cpu_done_o(cpu_done));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr
  task rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask : rd
  task wait_xfer(input int n);
    int k;
    k = 0;
    while (dmc_cpu_model_i.ntr < n && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    chk(16'(k < 300), 16'h0001);
    repeat (2) @(posedge clk_i);
  endtask : wait_xfer
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {rst_n_i, reg_we_i, reg_re_i, slow_q} = 4'h0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 16'h0000;
    irq_flag_i = 32'h0000_0000;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    rd(5'h07, 16'h0000);
    rd(5'h00, 16'h0000);
    rd(5'h0E, 16'h0000);
    $display("test reset done");
    wr(5'h01, 16'h0021);
    rd(5'h00, 16'h0002);
    rd(5'h01, 16'h0001);
    wr(5'h00, 16'h0002);
    rd(5'h00, 16'h0002);
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h0002);
    rd(5'h00, 16'h0000);
    $display("test pending done");
    wr(5'h02, 16'h2000);
    wr(5'h03, 16'h3000);
    wr(5'h04, 16'h0002);
    wr(5'h00, 16'h000F);
    rd(5'h05, 16'h2000);
    rd(5'h06, 16'h0002);
    rd(5'h00, 16'h000D);
    wr(5'h00, 16'h0015);
    rd(5'h05, 16'h3000);
    wr(5'h00, 16'h000D);
    rd(5'h05, 16'h2000);
    $display("test reload done");
    wr(5'h01, 16'h0021);
    wait_xfer(1);
    chk({8'h00, dmc_cpu_model_i.n_rd}, 16'h0001);
    chk({8'h00, dmc_cpu_model_i.n_wr}, 16'h0001);
    chk(dmc_cpu_model_i.wr_addr, 16'h3000);
    chk({8'h00, dmc_cpu_model_i.wr_data[7:0]}, 16'h00C3);
    rd(5'h05, 16'h2001);
    rd(5'h06, 16'h0001);
    rd(5'h00, 16'h000D);
    wr(5'h01, 16'h0021);
    wait_xfer(2);
    rd(5'h06, 16'h0000);
    rd(5'h00, 16'h0009);
    $display("test single unit done");
    for (int i = 0; i < 6; i++) begin
      wr(5'h10, T_CFG[i]);
      wr(5'h02, T_SRC[i]);
      wr(5'h03, T_DST[i]);
      wr(5'h04, 16'h0001);
      wr(5'h00, 16'h000C);
      wr(5'h01, 16'h0021);
      wait_xfer(3 + i);
      chk({8'h00, dmc_cpu_model_i.n_rd}, {8'h00, T_RD[i]});
      chk({8'h00, dmc_cpu_model_i.n_wr}, {8'h00, T_WR[i]});
      chk(dmc_cpu_model_i.wr_addr, T_DST[i] + {15'h0000, T_DST[i][0]});
    end
    wr(5'h10, 16'h0000);
    $display("test cycle table done");
    slow_q <= 1'b1;
    wr(5'h01, 16'h0005);
    wr(5'h09, 16'h0006);
    wr(5'h04, 16'h0002);
    wr(5'h02, 16'h2000);
    wr(5'h00, 16'h000D);
    wr(5'h0A, 16'h4000);
    wr(5'h0B, 16'h5000);
    wr(5'h0C, 16'h0002);
    wr(5'h08, 16'h000D);
    @(posedge clk_i);
    irq_flag_i <= 32'h0000_0060;
    @(posedge clk_i);
    irq_flag_i <= 32'h0000_0020;
    @(posedge clk_i);
    irq_flag_i <= 32'h0000_0060;
    wait_xfer(10);
    repeat (60) @(posedge clk_i);
    chk(16'(dmc_cpu_model_i.ntr), 16'h000A);
    chk(dmc_cpu_model_i.log_a[0], 16'h3000);
    chk(dmc_cpu_model_i.log_a[1], 16'h5000);
    rd(5'h0E, 16'h0001);
    rd(5'h06, 16'h0001);
    irq_flag_i <= 32'h0000_0000;
    $display("test priority done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// ---- verilog/dmc_coef.sv ----
// Purpose: bus-cycle coefficient and beat count for one access address
// Assumes: addresses below the sfr limit are special-function registers
// Notes:   purely combinational, used once for source and once for destination
`timescale 1ns/100ps
`default_nettype none
module dmc_coef (
  input  wire logic [dmc_pkg::AW-1:0] addr_i,
  input  wire logic                   wide_i,
  input  wire logic                   sfr_wait_i,
  input  wire logic                   mem_wait_i,
  output logic      [1:0]             coef_o,
  output logic                        two_beats_o
);

  logic is_sfr;

  assign is_sfr = (addr_i < dmc_pkg::SFR_TOP);

  // wait states stretch every bus cycle of the access
  assign coef_o = is_sfr ? (sfr_wait_i ? dmc_pkg::J_SFR_TWO : dmc_pkg::J_SFR_ONE)
                         : (mem_wait_i ? dmc_pkg::J_MEM_WAIT : dmc_pkg::J_MEM_NOWAIT);

  assign two_beats_o = wide_i & addr_i[0];

endmodule : dmc_coef
`default_nettype wire

// ---- verilog/dmc_pkg.sv ----
// Purpose: shared constants and types of the two-channel dma controller
// Assumes: 16-bit internal bus, 5-bit register address, one clock domain
// Notes:   register offsets are word indices on the plain register port
//
// Contract
// - unit cycles = reads times j plus writes times k
// - 16-bit odd address takes two bus cycles
// - j,k: 1/2 memory, 2/3 sfr by wait
// - enable write reloads forward pointer from source/destination
// - enable write reloads transfer counter
// - rewriting enable one repeats both reloads
// - request cause from source code plus extend
// - every request event sets pending flag
// - pending clears right before transfer begins
// - software can only clear pending, never set
// - software request bit sets pending when selected
// - peripheral request bit rising sets pending flag
// - both channels may set pending in one period
// - channel 0 served before channel 1
// - bus returns to cpu between channel transfers
// - requests collapse, one transfer per grant
// - enable bit readable by software
// - transfer is source read then destination write
// - each wait state lengthens access by one cycle
package dmc_pkg;

  localparam int unsigned AW    = 16;
  localparam int unsigned DW    = 16;
  localparam int unsigned RAW   = 5;
  localparam int unsigned NSRC  = 32;

  // per-channel register offsets inside an eight-word channel window, then the global wait register address
  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_SEL  = 3'h1;
  localparam logic [2:0] OFF_SAR  = 3'h2;
  localparam logic [2:0] OFF_DAR  = 3'h3;
  localparam logic [2:0] OFF_RLD  = 3'h4;
  localparam logic [2:0] OFF_PTR  = 3'h5;
  localparam logic [2:0] OFF_CNT  = 3'h6;
  localparam logic [4:0] OFF_WAIT = 5'h10;

  // channel_control_reg fields
  localparam int unsigned CTL_UNIT = 0;
  localparam int unsigned CTL_PEND = 1;
  localparam int unsigned CTL_EN   = 2;
  localparam int unsigned CTL_SFWD = 3;
  localparam int unsigned CTL_DFWD = 4;
  // request_select_reg fields
  localparam int unsigned SEL_EXT   = 4;
  localparam int unsigned SEL_SWREQ = 5;
  // wait configuration fields
  localparam int unsigned WT_SFR = 0;
  localparam int unsigned WT_MEM = 1;

  localparam logic [4:0]    SRC_SW  = 5'h01;
  localparam logic [AW-1:0] SFR_TOP = 16'h0400;

  localparam logic [1:0] J_MEM_NOWAIT = 2'h1;
  localparam logic [1:0] J_MEM_WAIT   = 2'h2;
  localparam logic [1:0] J_SFR_ONE    = 2'h2;
  localparam logic [1:0] J_SFR_TWO    = 2'h3;

  localparam logic [AW-1:0] RST_ADDR = 16'h0000;
  localparam logic [DW-1:0] RST_DATA = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WR   = 2'b10
  } dmc_state_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic          rd;
    logic          wr;
    logic          byte_acc;
    logic [DW-1:0] wdata;
  } dmc_mem_req_t;

endpackage : dmc_pkg

// ---- verilog/dmc_top.sv ----
// Purpose: two-channel dma engine taking the internal bus one unit at a time
// Assumes: peripheral request flags and cpu bus status are on clk_i
// Notes:   byte accesses carry data on the low byte lane of the bus
`timescale 1ns/100ps
`default_nettype none
module dmc_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic [dmc_pkg::RAW-1:0]     reg_addr_i,
  input  wire logic [dmc_pkg::DW-1:0]      reg_wdata_i,
  input  wire logic                        reg_we_i,
  input  wire logic                        reg_re_i,
  output logic      [dmc_pkg::DW-1:0]      reg_rdata_o,
  input  wire logic [dmc_pkg::NSRC-1:0]    irq_flag_i,
  input  wire logic                        cpu_access_done_i,
  input  wire logic [dmc_pkg::DW-1:0]      mem_rdata_i,
  output var dmc_pkg::dmc_mem_req_t        mem_req_o,
  output logic                             bus_hold_o
);

  localparam int unsigned AW = dmc_pkg::AW;
  localparam int unsigned DW = dmc_pkg::DW;

  // per-channel state
  logic          en_q     [2];
  logic          en_d     [2];
  logic          pend_q   [2];
  logic          pend_d   [2];
  logic          unit8_q  [2];
  logic          unit8_d  [2];
  logic          sfwd_q   [2];
  logic          sfwd_d   [2];
  logic          dfwd_q   [2];
  logic          dfwd_d   [2];
  logic [4:0]    srcsel_q [2];
  logic [4:0]    srcsel_d [2];
  logic          prev_q   [2];
  logic          prev_d   [2];
  logic [AW-1:0] sar_q    [2];
  logic [AW-1:0] sar_d    [2];
  logic [AW-1:0] dar_q    [2];
  logic [AW-1:0] dar_d    [2];
  logic [DW-1:0] rld_q    [2];
  logic [DW-1:0] rld_d    [2];
  logic [AW-1:0] ptr_q    [2];
  logic [AW-1:0] ptr_d    [2];
  logic [DW-1:0] cnt_q    [2];
  logic [DW-1:0] cnt_d    [2];
  logic [1:0]    start_ch;
  logic [1:0]    done_ch;

  // global state
  logic                  sfr_wait_q;
  logic                  sfr_wait_d;
  logic                  mem_wait_q;
  logic                  mem_wait_d;
  logic [DW-1:0]         rdata_q;
  logic [DW-1:0]         rdata_d;

  // engine state
  dmc_pkg::dmc_state_t   state_q;
  dmc_pkg::dmc_state_t   state_d;
  logic                  ch_q;
  logic                  ch_d;
  logic                  beat_q;
  logic                  beat_d;
  logic [1:0]            wcnt_q;
  logic [1:0]            wcnt_d;
  logic                  cpu_ok_q;
  logic                  cpu_ok_d;
  logic [DW-1:0]         data_q;
  logic [DW-1:0]         data_d;
  logic                  hold_q;
  logic                  hold_d;
  dmc_pkg::dmc_mem_req_t req_q;
  dmc_pkg::dmc_mem_req_t req_d;

  logic          ready0;
  logic          ready1;
  logic          pick;
  logic          cur;
  logic [AW-1:0] src_addr;
  logic [AW-1:0] dst_addr;
  logic [1:0]    coef_j;
  logic [1:0]    coef_k;
  logic          src_two;
  logic          dst_two;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic       hit;
      logic       ctl_wr;
      logic       sel_wr;
      logic       flag;
      logic       ev;
      logic       clr;
      logic [4:0] new_sel;

      assign hit    = reg_we_i & ~reg_addr_i[4] & (reg_addr_i[3] == 1'(gi));
      assign ctl_wr = hit & (reg_addr_i[2:0] == dmc_pkg::OFF_CTRL);
      assign sel_wr = hit & (reg_addr_i[2:0] == dmc_pkg::OFF_SEL);
      assign new_sel = {reg_wdata_i[dmc_pkg::SEL_EXT], reg_wdata_i[3:0]};
      // a change of selection can look like a rising flag; software clears after it
      assign flag = (srcsel_q[gi] == dmc_pkg::SRC_SW) ? 1'b0 : irq_flag_i[srcsel_q[gi]];

      always_comb begin
        ev = (flag & ~prev_q[gi])
           | (sel_wr & reg_wdata_i[dmc_pkg::SEL_SWREQ] & (new_sel == dmc_pkg::SRC_SW));
        clr = (ctl_wr & ~reg_wdata_i[dmc_pkg::CTL_PEND]) | start_ch[gi];
        pend_d[gi]   = (pend_q[gi] & ~clr) | ev;
        prev_d[gi]   = flag;
        en_d[gi]     = en_q[gi];
        unit8_d[gi]  = unit8_q[gi];
        sfwd_d[gi]   = sfwd_q[gi];
        dfwd_d[gi]   = dfwd_q[gi];
        srcsel_d[gi] = sel_wr ? new_sel : srcsel_q[gi];
        sar_d[gi] = (hit && reg_addr_i[2:0] == dmc_pkg::OFF_SAR) ? reg_wdata_i : sar_q[gi];
        dar_d[gi] = (hit && reg_addr_i[2:0] == dmc_pkg::OFF_DAR) ? reg_wdata_i : dar_q[gi];
        rld_d[gi] = (hit && reg_addr_i[2:0] == dmc_pkg::OFF_RLD) ? reg_wdata_i : rld_q[gi];
        ptr_d[gi] = ptr_q[gi];
        cnt_d[gi] = cnt_q[gi];
        if (done_ch[gi]) begin
          ptr_d[gi] = ptr_q[gi] + (unit8_q[gi] ? 16'h0001 : 16'h0002);
          cnt_d[gi] = cnt_q[gi] - 16'h0001;
          // single-shot: the last unit of the block disables the channel
          if (cnt_q[gi] == 16'h0001) begin
            en_d[gi] = 1'b0;
          end
        end
        if (ctl_wr) begin
          en_d[gi]    = reg_wdata_i[dmc_pkg::CTL_EN];
          unit8_d[gi] = reg_wdata_i[dmc_pkg::CTL_UNIT];
          sfwd_d[gi]  = reg_wdata_i[dmc_pkg::CTL_SFWD];
          dfwd_d[gi]  = reg_wdata_i[dmc_pkg::CTL_DFWD];
          // reload on every write of one, even when already enabled
          if (reg_wdata_i[dmc_pkg::CTL_EN]) begin
            ptr_d[gi] = reg_wdata_i[dmc_pkg::CTL_SFWD] ? sar_q[gi] : dar_q[gi];
            cnt_d[gi] = rld_q[gi];
          end
        end
      end

      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          en_q[gi]     <= 1'b0;
          pend_q[gi]   <= 1'b0;
          unit8_q[gi]  <= 1'b0;
          sfwd_q[gi]   <= 1'b0;
          dfwd_q[gi]   <= 1'b0;
          srcsel_q[gi] <= 5'h00;
          prev_q[gi]   <= 1'b0;
          sar_q[gi]    <= dmc_pkg::RST_ADDR;
          dar_q[gi]    <= dmc_pkg::RST_ADDR;
          rld_q[gi]    <= dmc_pkg::RST_DATA;
          ptr_q[gi]    <= dmc_pkg::RST_ADDR;
          cnt_q[gi]    <= dmc_pkg::RST_DATA;
        end else begin
          en_q[gi]     <= en_d[gi];
          pend_q[gi]   <= pend_d[gi];
          unit8_q[gi]  <= unit8_d[gi];
          sfwd_q[gi]   <= sfwd_d[gi];
          dfwd_q[gi]   <= dfwd_d[gi];
          srcsel_q[gi] <= srcsel_d[gi];
          prev_q[gi]   <= prev_d[gi];
          sar_q[gi]    <= sar_d[gi];
          dar_q[gi]    <= dar_d[gi];
          rld_q[gi]    <= rld_d[gi];
          ptr_q[gi]    <= ptr_d[gi];
          cnt_q[gi]    <= cnt_d[gi];
        end
      end
    end
  endgenerate

  // register read port and wait configuration
  always_comb begin
    sfr_wait_d = sfr_wait_q;
    mem_wait_d = mem_wait_q;
    rdata_d    = 16'h0000;
    if (reg_we_i && reg_addr_i == dmc_pkg::OFF_WAIT) begin
      sfr_wait_d = reg_wdata_i[dmc_pkg::WT_SFR];
      mem_wait_d = reg_wdata_i[dmc_pkg::WT_MEM];
    end
    if (reg_re_i) begin
      if (reg_addr_i == dmc_pkg::OFF_WAIT) begin
        rdata_d = {14'h0000, mem_wait_q, sfr_wait_q};
      end else if (!reg_addr_i[4]) begin
        case (reg_addr_i[2:0])
          dmc_pkg::OFF_CTRL: rdata_d = {11'h000, dfwd_q[reg_addr_i[3]], sfwd_q[reg_addr_i[3]],
                                        en_q[reg_addr_i[3]], pend_q[reg_addr_i[3]],
                                        unit8_q[reg_addr_i[3]]};
          dmc_pkg::OFF_SEL:  rdata_d = {11'h000, srcsel_q[reg_addr_i[3]]};
          dmc_pkg::OFF_SAR:  rdata_d = sar_q[reg_addr_i[3]];
          dmc_pkg::OFF_DAR:  rdata_d = dar_q[reg_addr_i[3]];
          dmc_pkg::OFF_RLD:  rdata_d = rld_q[reg_addr_i[3]];
          dmc_pkg::OFF_PTR:  rdata_d = ptr_q[reg_addr_i[3]];
          dmc_pkg::OFF_CNT:  rdata_d = cnt_q[reg_addr_i[3]];
          default:           rdata_d = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sfr_wait_q <= 1'b0;
      mem_wait_q <= 1'b0;
      rdata_q    <= 16'h0000;
    end else begin
      sfr_wait_q <= sfr_wait_d;
      mem_wait_q <= mem_wait_d;
      rdata_q    <= rdata_d;
    end
  end

  // arbitration and address selection
  assign ready0   = en_q[0] & pend_q[0];
  assign ready1   = en_q[1] & pend_q[1];
  assign pick     = ~ready0;
  assign cur      = (state_q == dmc_pkg::ST_IDLE) ? pick : ch_q;
  assign src_addr = sfwd_q[cur] ? ptr_q[cur] : sar_q[cur];
  assign dst_addr = (dfwd_q[cur] & ~sfwd_q[cur]) ? ptr_q[cur] : dar_q[cur];

  dmc_coef u_src_coef (
    .addr_i      (src_addr),
    .wide_i      (~unit8_q[cur]),
    .sfr_wait_i  (sfr_wait_q),
    .mem_wait_i  (mem_wait_q),
    .coef_o      (coef_j),
    .two_beats_o (src_two)
  );

  dmc_coef u_dst_coef (
    .addr_i      (dst_addr),
    .wide_i      (~unit8_q[cur]),
    .sfr_wait_i  (sfr_wait_q),
    .mem_wait_i  (mem_wait_q),
    .coef_o      (coef_k),
    .two_beats_o (dst_two)
  );

  // engine: each bus cycle holds its strobe for coef clocks
  always_comb begin
    state_d  = state_q;
    ch_d     = ch_q;
    beat_d   = beat_q;
    wcnt_d   = wcnt_q;
    data_d   = data_q;
    hold_d   = hold_q;
    req_d    = req_q;
    start_ch = 2'b00;
    done_ch  = 2'b00;
    // the cpu must finish one access of its own between two grants
    cpu_ok_d = cpu_ok_q | (cpu_access_done_i & ~hold_q);
    case (state_q)
      dmc_pkg::ST_IDLE: begin
        if (cpu_ok_q && (ready0 || ready1)) begin
          start_ch[pick] = 1'b1;
          ch_d          = pick;
          state_d       = dmc_pkg::ST_RD;
          beat_d        = 1'b0;
          wcnt_d        = 2'h0;
          hold_d        = 1'b1;
          req_d.addr    = src_addr;
          req_d.rd      = 1'b1;
          req_d.wr      = 1'b0;
          req_d.byte_acc = unit8_q[pick] | src_two;
          req_d.wdata   = 16'h0000;
        end
      end
      dmc_pkg::ST_RD: begin
        if (wcnt_q == coef_j - 2'h1) begin
          if (!src_two) begin
            data_d = unit8_q[ch_q] ? {8'h00, mem_rdata_i[7:0]} : mem_rdata_i;
          end else if (!beat_q) begin
            data_d = {data_q[15:8], mem_rdata_i[7:0]};
          end else begin
            data_d = {mem_rdata_i[7:0], data_q[7:0]};
          end
          wcnt_d = 2'h0;
          if (src_two && !beat_q) begin
            beat_d     = 1'b1;
            req_d.addr = src_addr + 16'h0001;
          end else begin
            state_d        = dmc_pkg::ST_WR;
            beat_d         = 1'b0;
            req_d.addr     = dst_addr;
            req_d.rd       = 1'b0;
            req_d.wr       = 1'b1;
            req_d.byte_acc = unit8_q[ch_q] | dst_two;
            req_d.wdata    = dst_two ? {8'h00, data_d[7:0]} : data_d;
          end
        end else begin
          wcnt_d = wcnt_q + 2'h1;
        end
      end
      dmc_pkg::ST_WR: begin
        if (wcnt_q == coef_k - 2'h1) begin
          wcnt_d = 2'h0;
          if (dst_two && !beat_q) begin
            beat_d      = 1'b1;
            req_d.addr  = dst_addr + 16'h0001;
            req_d.wdata = {8'h00, data_q[15:8]};
          end else begin
            // one unit per grant, then the bus goes back to the cpu
            done_ch[ch_q] = 1'b1;
            state_d       = dmc_pkg::ST_IDLE;
            hold_d        = 1'b0;
            cpu_ok_d      = 1'b0;
            req_d         = '0;
          end
        end else begin
          wcnt_d = wcnt_q + 2'h1;
        end
      end
      default: begin
        state_d = dmc_pkg::ST_IDLE;
        hold_d  = 1'b0;
        req_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q  <= dmc_pkg::ST_IDLE;
      ch_q     <= 1'b0;
      beat_q   <= 1'b0;
      wcnt_q   <= 2'h0;
      cpu_ok_q <= 1'b1;
      data_q   <= 16'h0000;
      hold_q   <= 1'b0;
      req_q    <= '0;
    end else begin
      state_q  <= state_d;
      ch_q     <= ch_d;
      beat_q   <= beat_d;
      wcnt_q   <= wcnt_d;
      cpu_ok_q <= cpu_ok_d;
      data_q   <= data_d;
      hold_q   <= hold_d;
      req_q    <= req_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign mem_req_o   = req_q;
  assign bus_hold_o  = hold_q;

endmodule : dmc_top
`default_nettype wire
